// File: shared/chg_twi_cfg.svh
// Constants for the charger two-wire port and its test master
`ifndef CHG_TWI_CFG_SVH
`define CHG_TWI_CFG_SVH

`define CLK_HZ              25000000
`define STD_RATE_BPS        100000
`define HOST_QUARTER_CYCLES (`CLK_HZ / (4 * `STD_RATE_BPS))
`define SLAVE_ADDR          7'h6a
`define REG_STATUS          8'h00
`define UNMAPPED_READ       8'hff
`define WD_ON_RESET         1'b0
`define WD_ON_BIT           6
`define WDOG_TIME_S         50
`define WDOG_CYCLES         (`WDOG_TIME_S * `CLK_HZ)
`define XFER_TIMEOUT_CYCLES 250000
`define FAULT_NORMAL        4'h0
`define FAULT_LDO_LOW       4'ha
`define FAULT_LAST_USED     4'ha
`define FQ_DEPTH            4
`define HOST_CMD_ADDR       8'h00
`define HOST_STAT_ADDR      8'h04
`define CMD_READ_BIT        16

`endif

// File: shared/chg_twi_pkg.sv
// Types shared by the charger slave and the bus master
package chg_twi_pkg;
`include "chg_twi_cfg.svh"

	typedef enum logic [6:0] {
		S_IDLE     = 7'h01,
		S_ADDR     = 7'h02,
		S_ADDR_ACK = 7'h04,
		S_WR_DATA  = 7'h08,
		S_WR_ACK   = 7'h10,
		S_RD_DATA  = 7'h20,
		S_RD_ACK   = 7'h40
	} slave_state_t;

	typedef enum logic [3:0] {
		M_IDLE  = 4'h1,
		M_START = 4'h2,
		M_XFER  = 4'h4,
		M_STOP  = 4'h8
	} master_state_t;

	typedef struct packed {
		slave_state_t                 st;
		logic                         scl_s1;
		logic                         scl_s2;
		logic                         scl_p;
		logic                         sda_s1;
		logic                         sda_s2;
		logic                         sda_p;
		logic [3:0]                   bitn;
		logic [7:0]                   sh;
		logic                         rw;
		logic                         first;
		logic [7:0]                   ptr;
		logic                         nack;
		logic                         busy;
		logic [31:0]                  tmo;
		logic [31:0]                  wd_cnt;
		logic                         wd_on;
		logic                         wd_exp;
		logic                         host_mode;
		logic                         load_def;
		logic [`FQ_DEPTH-1:0][3:0]    fq;
		logic [2:0]                   fcnt;
		logic                         ldo_p;
		logic                         sda_out;
		logic                         sda_oe_n;
	} slave_regs_t;

	typedef struct packed {
		master_state_t st;
		logic [1:0]    ph;
		logic [7:0]    qdiv;
		logic [1:0]    idx;
		logic [3:0]    bitn;
		logic [7:0]    sh;
		logic [7:0]    rx;
		logic          rd;
		logic [7:0]    ptr;
		logic [7:0]    wdat;
		logic          busy;
		logic          nack;
		logic          ackb;
		logic          sda_s1;
		logic          sda_s2;
		logic          scl_out;
		logic          scl_oe_n;
		logic          sda_out;
		logic          sda_oe_n;
		logic [31:0]   rdata;
	} master_regs_t;

endpackage : chg_twi_pkg

// File: shared/twi_link_if.sv
// Two-wire bus between master and charger slave, open drain with pull-ups
`timescale 1ns/1ps
interface twi_link_if;
	logic scl_line;
	logic sda_line;
	logic m_scl_out;
	logic m_scl_oe_n;
	logic m_sda_out;
	logic m_sda_oe_n;
	logic s_sda_out;
	logic s_sda_oe_n;

	// Released pins read high through the pull-up
	assign scl_line = m_scl_oe_n | m_scl_out;
	assign sda_line = (m_sda_oe_n | m_sda_out) & (s_sda_oe_n | s_sda_out);

	modport master (
		input  sda_line,
		output m_scl_out,
		output m_scl_oe_n,
		output m_sda_out,
		output m_sda_oe_n
	);

	modport slave (
		input  scl_line,
		input  sda_line,
		output s_sda_out,
		output s_sda_oe_n
	);
endinterface : twi_link_if

// File: verilog/chg_twi_slave.sv
// Charger two-wire slave port with status register, watchdog and fault queue
// Functional notes
// - Slave only, standard and fast rate
// - Answer only fixed 7-bit address
// - Transaction timeout resets serial engine
// - START restarts timeout, STOP stops it
// - Master opens with START condition
// - Master sends address plus direction bit
// - Data changes only while clock low
// - Acknowledge matching address on ninth clock
// - Direction bit selects write or read
// - Eight data bits plus acknowledge, repeating
// - Master ends with STOP, link released
// - After STOP idle until matching START
// - Master sends STOP after abandoned transfer
// - Unmapped register reads return 0xff
// - Sticky watchdog expired flag, read only
// - Watchdog enable bit, writing one restarts
// - Charge state reported in bits 5:4
// - Fault code reported in bits 3:0
// - Faults queued, one per read
// - Input fault with LDO low code
// - Completed register write restarts watchdog
// - Expiry leaves host mode, reloads defaults
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "chg_twi_cfg.svh"
module chg_twi_slave #(
	parameter int unsigned XFER_TIMEOUT_CYCLES = `XFER_TIMEOUT_CYCLES,
	parameter int unsigned WDOG_CYCLES         = `WDOG_CYCLES
) (
	// Clock and reset
	input  wire logic       core_clk_in,
	input  wire logic       rst_b_in,
	// Serial bus
	twi_link_if.slave       tw,
	// Charger core status
	input  wire logic [1:0] charge_state_in,
	input  wire logic       fault_event_in,
	input  wire logic [3:0] fault_code_in,
	input  wire logic       fault_active_in,
	input  wire logic       ldo_low_in,
	input  wire logic       input_undervoltage_lockout_in,
	input  wire logic       input_undervoltage_lockout_exit_in,
	// Mode outputs
	output logic            host_mode_out,
	output logic            watchdog_timer_on_out,
	output logic            load_defaults_out
);

	chg_twi_pkg::slave_regs_t q;
	chg_twi_pkg::slave_regs_t d;

	logic       rise;
	logic       fall;
	logic       start_c;
	logic       stop_c;
	logic [3:0] live_code;
	logic [3:0] shown_code;
	logic [7:0] status_byte;
	logic [7:0] rd_byte;
	logic       ldo_fault;
	logic       push;
	logic [3:0] push_code;
	logic       pop;
	logic       wr_done;
	logic       wr_reg0;

	// Codes beyond the last defined one are treated as no fault
	assign live_code = (fault_active_in && fault_code_in <= `FAULT_LAST_USED) ?
		fault_code_in : `FAULT_NORMAL;
	assign shown_code  = (q.fcnt != 3'd0) ? q.fq[0] : live_code;
	assign status_byte = {q.wd_exp, q.wd_on, charge_state_in, shown_code};
	assign rd_byte     = (q.ptr == `REG_STATUS) ? status_byte : `UNMAPPED_READ;
	assign ldo_fault   = ldo_low_in & (input_undervoltage_lockout_in | input_undervoltage_lockout_exit_in);
	assign push        = (ldo_fault & ~q.ldo_p) |
		(fault_event_in & fault_code_in != `FAULT_NORMAL &
		fault_code_in <= `FAULT_LAST_USED);
	// The LDO fault wins a same-cycle collision; the other event is lost
	assign push_code   = (ldo_fault & ~q.ldo_p) ? `FAULT_LDO_LOW : fault_code_in;

	assign rise    = q.scl_s2 & ~q.scl_p;
	assign fall    = ~q.scl_s2 & q.scl_p;
	assign start_c = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
	assign stop_c  = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;

	always_comb begin
		d          = q;
		d.load_def = 1'b0;
		pop        = 1'b0;
		wr_done    = 1'b0;
		wr_reg0    = 1'b0;
		d.scl_s1   = tw.scl_line;
		d.scl_s2   = q.scl_s1;
		d.scl_p    = q.scl_s2;
		d.sda_s1   = tw.sda_line;
		d.sda_s2   = q.sda_s1;
		d.sda_p    = q.sda_s2;
		d.ldo_p    = ldo_fault;
		if (q.busy) begin
			d.tmo = q.tmo + 32'd1;
		end
		// Sampling on the core clock gives one protocol for both bus rates
		if (start_c) begin
			d.st       = chg_twi_pkg::S_ADDR;
			d.bitn     = 4'd0;
			d.busy     = 1'b1;
			d.tmo      = 32'd0;
			d.sda_oe_n = 1'b1;
		end else if (stop_c) begin
			d.st       = chg_twi_pkg::S_IDLE;
			d.busy     = 1'b0;
			d.sda_oe_n = 1'b1;
		end else if (q.busy && q.tmo == XFER_TIMEOUT_CYCLES - 1) begin
			d.st       = chg_twi_pkg::S_IDLE;
			d.busy     = 1'b0;
			d.sda_oe_n = 1'b1;
		end else begin
			case (q.st)
				chg_twi_pkg::S_IDLE: begin
					d.sda_oe_n = 1'b1;
				end
				chg_twi_pkg::S_ADDR: begin
					if (rise) begin
						d.sh   = {q.sh[6:0], q.sda_s2};
						d.bitn = q.bitn + 4'd1;
					end else if (fall && q.bitn == 4'd8) begin
						if (q.sh[7:1] == `SLAVE_ADDR) begin
							d.rw       = q.sh[0];
							d.sda_oe_n = 1'b0;
							d.st       = chg_twi_pkg::S_ADDR_ACK;
						end else begin
							d.st = chg_twi_pkg::S_IDLE;
						end
					end
				end
				chg_twi_pkg::S_ADDR_ACK: begin
					if (fall) begin
						d.bitn  = 4'd0;
						d.first = 1'b1;
						if (q.rw) begin
							d.sh       = rd_byte;
							d.sda_oe_n = rd_byte[7];
							d.st       = chg_twi_pkg::S_RD_DATA;
							pop        = (q.ptr == `REG_STATUS);
						end else begin
							d.sda_oe_n = 1'b1;
							d.st       = chg_twi_pkg::S_WR_DATA;
						end
					end
				end
				chg_twi_pkg::S_WR_DATA: begin
					if (rise) begin
						d.sh   = {q.sh[6:0], q.sda_s2};
						d.bitn = q.bitn + 4'd1;
					end else if (fall && q.bitn == 4'd8) begin
						d.sda_oe_n = 1'b0;
						d.st       = chg_twi_pkg::S_WR_ACK;
						if (q.first) begin
							d.ptr   = q.sh;
							d.first = 1'b0;
						end else begin
							wr_done = 1'b1;
							wr_reg0 = (q.ptr == `REG_STATUS);
							d.ptr   = q.ptr + 8'd1;
						end
					end
				end
				chg_twi_pkg::S_WR_ACK: begin
					if (fall) begin
						d.sda_oe_n = 1'b1;
						d.bitn     = 4'd0;
						d.st       = chg_twi_pkg::S_WR_DATA;
					end
				end
				chg_twi_pkg::S_RD_DATA: begin
					if (fall) begin
						if (q.bitn == 4'd7) begin
							d.sda_oe_n = 1'b1;
							d.st       = chg_twi_pkg::S_RD_ACK;
							d.ptr      = q.ptr + 8'd1;
						end else begin
							d.sh       = {q.sh[6:0], 1'b0};
							d.sda_oe_n = q.sh[6];
							d.bitn     = q.bitn + 4'd1;
						end
					end
				end
				chg_twi_pkg::S_RD_ACK: begin
					if (rise) begin
						d.nack = q.sda_s2;
					end else if (fall) begin
						if (q.nack) begin
							d.st = chg_twi_pkg::S_IDLE;
						end else begin
							d.sh       = rd_byte;
							d.sda_oe_n = rd_byte[7];
							d.bitn     = 4'd0;
							d.st       = chg_twi_pkg::S_RD_DATA;
							pop        = (q.ptr == `REG_STATUS);
						end
					end
				end
				default: begin
					d.st       = chg_twi_pkg::S_IDLE;
					d.sda_oe_n = 1'b1;
				end
			endcase
		end

		// Fault queue: pop first, then append, so a full queue accepts on a read
		if (pop && q.fcnt != 3'd0) begin
			d.fq   = {`FAULT_NORMAL, q.fq[`FQ_DEPTH-1:1]};
			d.fcnt = q.fcnt - 3'd1;
		end
		if (push && d.fcnt < 3'(`FQ_DEPTH)) begin
			d.fq[d.fcnt[1:0]] = push_code;
			d.fcnt            = d.fcnt + 3'd1;
		end

		// Watchdog: any completed write proves the host alive
		if (wr_done) begin
			d.host_mode = 1'b1;
			d.wd_cnt    = 32'd0;
			if (wr_reg0) begin
				d.wd_on = q.sh[`WD_ON_BIT];
			end
		end else if (q.wd_on) begin
			if (q.wd_cnt == WDOG_CYCLES - 1) begin
				d.wd_exp    = 1'b1;
				d.host_mode = 1'b0;
				d.load_def  = 1'b1;
				d.wd_cnt    = 32'd0;
			end else begin
				d.wd_cnt = q.wd_cnt + 32'd1;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			q          <= '0;
			q.st       <= chg_twi_pkg::S_IDLE;
			q.scl_s1   <= 1'b1;
			q.scl_s2   <= 1'b1;
			q.scl_p    <= 1'b1;
			q.sda_s1   <= 1'b1;
			q.sda_s2   <= 1'b1;
			q.sda_p    <= 1'b1;
			q.wd_on    <= `WD_ON_RESET;
			q.sda_oe_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign tw.s_sda_out          = q.sda_out;
	assign tw.s_sda_oe_n         = q.sda_oe_n;
	assign host_mode_out         = q.host_mode;
	assign watchdog_timer_on_out = q.wd_on;
	assign load_defaults_out     = q.load_def;

endmodule : chg_twi_slave

// File: verilog/twi_bus_master.sv
// Two-wire bus master: one register write or one register read per command
`timescale 1ns/1ps
`include "chg_twi_cfg.svh"
module twi_bus_master (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_b_in,
	// Serial bus
	twi_link_if.master       tw,
	// Command port
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic [31:0]      rdata_out,
	output logic             busy_out
);

	chg_twi_pkg::master_regs_t q;
	chg_twi_pkg::master_regs_t d;

	logic tick;

	assign tick = (q.qdiv == 8'(`HOST_QUARTER_CYCLES - 1));

	always_comb begin
		d        = q;
		d.sda_s1 = tw.sda_line;
		d.sda_s2 = q.sda_s1;
		d.qdiv   = tick ? 8'd0 : q.qdiv + 8'd1;
		d.rdata  = 32'h0;
		if (rd_in && addr_in == `HOST_STAT_ADDR) begin
			d.rdata = {22'h0, q.nack, q.busy, q.rx};
		end
		if (wr_in && addr_in == `HOST_CMD_ADDR && !q.busy) begin
			d.busy = 1'b1;
			d.nack = 1'b0;
			d.rd   = wdata_in[`CMD_READ_BIT];
			d.ptr  = wdata_in[7:0];
			d.wdat = wdata_in[15:8];
			d.idx  = 2'd0;
			d.ph   = 2'd0;
			d.sh   = {`SLAVE_ADDR, 1'b0};
			d.st   = chg_twi_pkg::M_START;
		end else if (tick) begin
			d.ph = q.ph + 2'd1;
			case (q.st)
				chg_twi_pkg::M_IDLE: begin
					d.ph = 2'd0;
				end
				chg_twi_pkg::M_START: begin
					case (q.ph)
						2'd0: d.sda_oe_n = 1'b1;
						2'd1: d.scl_oe_n = 1'b1;
						2'd2: d.sda_oe_n = 1'b0;
						default: begin
							d.scl_oe_n = 1'b0;
							d.bitn     = 4'd0;
							d.st       = chg_twi_pkg::M_XFER;
						end
					endcase
				end
				chg_twi_pkg::M_XFER: begin
					case (q.ph)
						2'd0: d.sda_oe_n = (q.bitn < 4'd8 && q.idx != 2'd3) ? q.sh[7] : 1'b1;
						2'd1: d.scl_oe_n = 1'b1;
						2'd2: begin
							if (q.bitn < 4'd8) begin
								d.sh = {q.sh[6:0], q.sda_s2};
							end else begin
								d.ackb = q.sda_s2;
							end
						end
						default: begin
							d.scl_oe_n = 1'b0;
							d.bitn     = q.bitn + 4'd1;
							if (q.bitn == 4'd8) begin
								d.bitn = 4'd0;
								if (q.idx != 2'd3 && q.ackb) begin
									d.nack = 1'b1;
									d.st   = chg_twi_pkg::M_STOP;
								end else if (q.idx == 2'd3) begin
									d.rx = q.sh;
									d.st = chg_twi_pkg::M_STOP;
								end else if (q.idx == 2'd0) begin
									d.idx = 2'd1;
									d.sh  = q.ptr;
								end else if (q.idx == 2'd1 && q.rd) begin
									d.idx = 2'd2;
									d.sh  = {`SLAVE_ADDR, 1'b1};
									d.st  = chg_twi_pkg::M_START;
								end else if (q.idx == 2'd1) begin
									d.idx = 2'd2;
									d.sh  = q.wdat;
								end else if (q.rd) begin
									d.idx = 2'd3;
								end else begin
									d.st = chg_twi_pkg::M_STOP;
								end
							end
						end
					endcase
				end
				chg_twi_pkg::M_STOP: begin
					case (q.ph)
						2'd0: d.sda_oe_n = 1'b0;
						2'd1: d.scl_oe_n = 1'b1;
						2'd2: d.sda_oe_n = 1'b1;
						default: begin
							d.busy = 1'b0;
							d.st   = chg_twi_pkg::M_IDLE;
						end
					endcase
				end
				default: begin
					d.st = chg_twi_pkg::M_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			q          <= '0;
			q.st       <= chg_twi_pkg::M_IDLE;
			q.sda_s1   <= 1'b1;
			q.sda_s2   <= 1'b1;
			q.scl_oe_n <= 1'b1;
			q.sda_oe_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign tw.m_scl_out  = q.scl_out;
	assign tw.m_scl_oe_n = q.scl_oe_n;
	assign tw.m_sda_out  = q.sda_out;
	assign tw.m_sda_oe_n = q.sda_oe_n;
	assign rdata_out     = q.rdata;
	assign busy_out      = q.busy;

endmodule : twi_bus_master

// File: bench/chg_twi_link_asserts.sv
// Protocol checks on the two-wire link between bus master and charger slave
`timescale 1ns/1ps
module chg_twi_link_asserts (
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic rst_b_in,
	// Bus lines and pin drivers
	input  wire logic scl_line,
	input  wire logic sda_line,
	input  wire logic m_scl_out,
	input  wire logic m_scl_oe_n,
	input  wire logic m_sda_out,
	input  wire logic m_sda_oe_n,
	input  wire logic s_sda_out,
	input  wire logic s_sda_oe_n
);
	logic       scl_q;
	logic       sda_q;
	logic       idle_q;
	logic       rep_q;
	logic [3:0] nbits_q;
	logic [3:0] unit_q;
	logic       rise;
	logic       start;
	logic       stop;
	logic [7:0] abyte;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	assign rise  = scl_line & ~scl_q;
	assign start = scl_line & scl_q & sda_q & ~sda_line;
	assign stop  = scl_line & scl_q & ~sda_q & sda_line;
	assign abyte = rep_q ? 8'hd5 : 8'hd4;

	// Counters restart at each START, so the rise that opens a START is not counted
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			scl_q   <= 1'h1;
			sda_q   <= 1'h1;
			idle_q  <= 1'h1;
			rep_q   <= 1'h0;
			nbits_q <= 4'hf;
			unit_q  <= 4'h0;
		end else begin
			scl_q <= scl_line;
			sda_q <= sda_line;
			if (start) begin
				idle_q  <= 1'h0;
				rep_q   <= ~idle_q;
				nbits_q <= 4'h0;
				unit_q  <= 4'h0;
			end else begin
				if (stop)
					idle_q <= 1'h1;
				if (rise && nbits_q != 4'hf)
					nbits_q <= nbits_q + 4'h1;
				if (rise)
					unit_q <= (unit_q == 4'h8) ? 4'h0 : unit_q + 4'h1;
			end
		end
	end

	outs_zero_a: assert property (!m_scl_out && !m_sda_out && !s_sda_out)
		else $error("pin driven high instead of released");
	hold_stable_a: assert property (scl_line && $past(scl_line) |-> $stable(s_sda_oe_n))
		else $error("slave data changed while clock high");
	ack_ninth_a: assert property (rise && nbits_q == 4'h8 |-> (!s_sda_oe_n && !sda_line)[*8])
		else $error("address not acknowledged on ninth clock");
	addr_quiet_a: assert property (nbits_q < 4'h8 |-> s_sda_oe_n)
		else $error("slave drove data during address");
	addr_bits_a: assert property (rise && nbits_q < 4'h8 && !idle_q
		|-> sda_line == abyte[3'h7 - nbits_q[2:0]])
		else $error("address or direction bit wrong");
	idle_quiet_a: assert property (idle_q |-> s_sda_oe_n)
		else $error("slave drove data while bus free");
	idle_high_a: assert property (idle_q && !start |=> scl_line)
		else $error("clock low while bus free");
	unit_count_a: assert property (stop |-> unit_q == 4'h1)
		else $error("frame not whole nine-bit units");
	data_hold_a: assert property (scl_line && $past(scl_line) && !start && !stop
		|-> $stable(m_sda_oe_n))
		else $error("master data changed while clock high");
	clk_release_a: assert property (idle_q |-> m_scl_oe_n)
		else $error("master held clock while bus free");
endmodule : chg_twi_link_asserts

// File: bench/testbench.sv
// Bench joining the bus master and charger slave over the two-wire link
`timescale 1ns/1ps
module testbench;
	// Shortened so that one expiry fits in the run
	localparam int unsigned WD_CYC = 4000;
	localparam int unsigned TO_CYC = 20000;
	logic        core_clk_in     = 1'h0;
	logic        rst_b_in        = 1'h0;
	logic [7:0]  addr_in         = 8'h00;
	logic [31:0] wdata_in        = 32'h0;
	logic        wr_in           = 1'h0;
	logic        rd_in           = 1'h0;
	logic [1:0]  charge_state_in = 2'h0;
	logic        fault_event_in  = 1'h0;
	logic [3:0]  fault_code_in   = 4'h0;
	logic        ldo_low_in      = 1'h0;
	logic        lockout_in      = 1'h0;
	logic        fault_active_in = 1'h0;
	logic        input_undervoltage_lockout_exit_in    = 1'h0;
	logic [31:0] rdata_out;
	logic        busy_out;
	logic        host_mode_out;
	logic        watchdog_timer_on_out;
	logic        load_defaults_out;
	int          failures        = 0;
	int          checks          = 0;
	int          cycles          = 0;

	twi_link_if u_twi_link_if ();
	chg_twi_slave #(.XFER_TIMEOUT_CYCLES(TO_CYC), .WDOG_CYCLES(WD_CYC)) u_chg_twi_slave (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .tw(u_twi_link_if),
		.charge_state_in(charge_state_in), .fault_event_in(fault_event_in),
		.fault_code_in(fault_code_in), .fault_active_in(fault_active_in),
		.ldo_low_in(ldo_low_in), .input_undervoltage_lockout_in(lockout_in),
		.input_undervoltage_lockout_exit_in(input_undervoltage_lockout_exit_in),
		.host_mode_out(host_mode_out), .watchdog_timer_on_out(watchdog_timer_on_out),
		.load_defaults_out(load_defaults_out));
	twi_bus_master u_twi_bus_master (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .tw(u_twi_link_if),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .busy_out(busy_out));
	chg_twi_link_asserts u_chg_twi_link_asserts (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.scl_line(u_twi_link_if.scl_line), .sda_line(u_twi_link_if.sda_line),
		.m_scl_out(u_twi_link_if.m_scl_out), .m_scl_oe_n(u_twi_link_if.m_scl_oe_n),
		.m_sda_out(u_twi_link_if.m_sda_out), .m_sda_oe_n(u_twi_link_if.m_sda_oe_n),
		.s_sda_out(u_twi_link_if.s_sda_out), .s_sda_oe_n(u_twi_link_if.s_sda_oe_n));

	always #20 core_clk_in = ~core_clk_in;

	task automatic results();
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One command to the master, wait for its STOP, then fetch its status word
	task automatic xfer(input logic [16:0] w, output logic [31:0] st);
		int n;
		@(posedge core_clk_in);
		wr_in    <= 1'h1;
		addr_in  <= 8'h00;
		wdata_in <= {15'h0, w};
		@(posedge core_clk_in);
		wr_in <= 1'h0;
		n = 0;
		do begin
			@(posedge core_clk_in);
			#1;
			n++;
		end while (busy_out !== 1'h0 && n < 20000);
		@(posedge core_clk_in);
		rd_in   <= 1'h1;
		addr_in <= 8'h04;
		@(posedge core_clk_in);
		rd_in <= 1'h0;
		#1;
		st = rdata_out;
		check({6'h0, st[9:8]}, 8'h00);
	endtask : xfer

	task automatic rd_reg(input logic [7:0] p, output logic [7:0] v);
		logic [31:0] st;
		xfer({1'h1, 8'h00, p}, st);
		v = st[7:0];
	endtask : rd_reg

	task automatic t_faults();
		logic [7:0] v;
		logic [3:0] q [4];
		q = '{4'h3, 4'h7, 4'ha, 4'h0};
		@(posedge core_clk_in);
		fault_code_in  <= 4'h3;
		fault_event_in <= 1'h1;
		@(posedge core_clk_in);
		fault_code_in <= 4'h7;
		@(posedge core_clk_in);
		fault_event_in <= 1'h0;
		lockout_in     <= 1'h1;
		ldo_low_in     <= 1'h1;
		@(posedge core_clk_in);
		lockout_in <= 1'h0;
		ldo_low_in <= 1'h0;
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk_in);
			charge_state_in <= 2'(i);
			rd_reg(8'h00, v);
			check(v, {2'h0, 2'(i), q[i]});
		end
		// Leaving lockout with the LDO still low queues the same code
		@(posedge core_clk_in);
		ldo_low_in   <= 1'h1;
		input_undervoltage_lockout_exit_in <= 1'h1;
		@(posedge core_clk_in);
		ldo_low_in   <= 1'h0;
		input_undervoltage_lockout_exit_in <= 1'h0;
		rd_reg(8'h00, v);
		check(v, 8'h3a);
	endtask : t_faults

	task automatic t_watchdog();
		logic [31:0] st;
		logic [7:0]  v;
		int          n;
		xfer({1'h0, 8'h40, 8'h00}, st);
		check({6'h0, host_mode_out, watchdog_timer_on_out}, 8'h03);
		n = 0;
		while (load_defaults_out !== 1'h1 && n < WD_CYC + 2000) begin
			@(posedge core_clk_in);
			#1;
			n++;
		end
		check({7'h0, n > WD_CYC - 1000 && n <= WD_CYC}, 8'h01);
		@(posedge core_clk_in);
		#1;
		check({7'h0, host_mode_out}, 8'h00);
		// A persisting fault shows once the queue is empty
		@(posedge core_clk_in);
		fault_code_in   <= 4'h5;
		fault_active_in <= 1'h1;
		rd_reg(8'h00, v);
		check({7'h0, v[7]}, 8'h01);
		check({4'h0, v[3:0]}, 8'h05);
	endtask : t_watchdog

	task automatic t_unmapped();
		logic [7:0] v;
		rd_reg(8'h05, v);
		check(v, 8'hff);
	endtask : t_unmapped

	task automatic t_disable();
		logic [31:0] st;
		xfer({1'h0, 8'h00, 8'h00}, st);
		check({7'h0, watchdog_timer_on_out}, 8'h00);
	endtask : t_disable

	// A hung transfer must not stall the run
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 100000) begin
			failures++;
			results();
		end
	end

	initial begin
		repeat (10) @(posedge core_clk_in);
		rst_b_in <= 1'h1;
		repeat (4) @(posedge core_clk_in);
		t_faults();
		t_watchdog();
		t_unmapped();
		t_disable();
		results();
	end
endmodule : testbench
